// ### verilog/cia_pkg.sv
// Constants, types and carriers for the CPU internal access decoder
package cia_pkg;
   localparam logic [15:0] VEC_HI = 16'h002f;
   localparam logic [15:0] ROM_LO = 16'h0030;
   localparam logic [15:0] ROM_HI = 16'h7fff;
   localparam logic [15:0] IO1_LO = 16'hf770;
   localparam logic [15:0] IO1_HI = 16'hf77f;
   localparam logic [15:0] RAM_LO = 16'hfb80;
   localparam logic [15:0] RAM_HI = 16'hff7f;
   localparam logic [15:0] IO2_LO = 16'hffa0;
   localparam logic [15:0] SCI_LO = 16'hffa8;
   localparam logic [15:0] SCI_HI = 16'hffad;
   localparam logic [15:0] TMV_LO = 16'hffb8;
   localparam logic [15:0] TMV_HI = 16'hffbd;
   localparam logic [15:0] RLD_ADDR = 16'hffb3;
   localparam logic [15:0] PDATA_ADDR = 16'hffd6;
   localparam logic [15:0] PDIR_ADDR = 16'hffe6;
   localparam logic [15:0] STACK_STEP = 16'h0002;
   localparam logic [1:0] ST_FAST = 2'd2;
   localparam logic [1:0] ST_SLOW = 2'd3;
   localparam int RAM_WORDS = 512;
   localparam int RAM_AW = 9;
   localparam logic [7:0] PDATA_RST = 8'h00;
   localparam logic [7:0] PDIR_RST = 8'h00;
   localparam logic [7:0] RLD_RST = 8'h00;
   localparam logic [7:0] WO_READ = 8'hff;
   localparam logic [7:0] RLD_TOP = 8'hff;

   typedef enum logic [2:0] {BOP_NONE, BOP_SET, BOP_CLR, BOP_INV, BOP_STO, BOP_ISTO} cia_bop_e;
   typedef enum logic [2:0] {RG_EMPTY, RG_VEC, RG_ROM, RG_RAM, RG_IO} cia_rgn_e;

   typedef struct packed {
      logic valid;
      logic we;
      logic word;
      logic [15:0] addr;
      logic [15:0] wdata;
      cia_bop_e op;
      logic [2:0] bitn;
      logic carry;
   } cia_req_s;

   typedef struct packed {
      logic valid;
      logic irq;
      logic [15:0] pc;
      logic [7:0] condition_code_reg;
      logic [15:0] sp;
   } cia_exc_s;

   typedef struct packed {
      logic we;
      logic word;
      logic [15:0] addr;
      logic [15:0] wdata;
   } cia_acc_s;

   typedef struct packed {
      logic stb;
      logic we;
      logic [15:0] addr;
      logic [7:0] wdata;
   } cia_per_s;
endpackage

// ### verilog/cia_top.sv
// CPU internal access decoder: area decode, wait states, byte bus, bit RMW, exception push
// How it works
// RULE1 - Reset or interrupt enters transient exception state
// RULE2 - Interrupt pushes PC and CONDITION_CODE_REG via stack
// RULE3 - Every address classed RAM, register, ROM, empty
// RULE4 - Writes to empty space are discarded
// RULE5 - Empty space reads return undefined data
// RULE6 - Peripheral transfers use an eight-bit path
// RULE7 - Word write to I/O keeps upper byte
// RULE8 - Word read from I/O: byte in upper half
// RULE9 - Lowest 48 bytes decode as vector area
// RULE10 - Low sixteen-byte I/O block, three states
// RULE11 - High 96-byte I/O block, two or three
// RULE12 - Timer and serial windows take three states
// RULE13 - Bit instructions read, modify, write whole byte
// RULE14 - Shared reload address reads the counter
// RULE15 - Shared reload address writes the load register
// RULE16 - Port read: pins for inputs, latch outputs
// RULE17 - Software should keep a port shadow copy
// RULE18 - One state is one clock edge to next
// RULE19 - ROM and RAM take two states, 16 bits
// RULE20 - Write-only bits read back as ones
// RULE21 - RMW write hits same address, nothing between
// RULE22 - Modify changes only the selected bit
module cia_top
   import cia_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire cia_pkg::cia_req_s cpu_req,
   input wire cia_pkg::cia_exc_s exc_req,
   input wire logic [15:0] rom_rdata,
   input wire logic [7:0] per_rdata,
   input wire logic [7:0] port_pin,
   output cia_pkg::cia_per_s per_bus,
   output logic [15:0] rom_addr,
   output logic cpu_busy,
   output logic cpu_ack,
   output logic [15:0] cpu_rdata,
   output logic exc_busy,
   output logic exc_done,
   output logic [15:0] exc_sp,
   output logic [7:0] port_out,
   output logic [7:0] port_oe
);
   import cia_pkg::*;

   typedef enum logic [6:0] {
      S_IDLE = 7'h01,
      S_CPU = 7'h02,
      S_RMWR = 7'h04,
      S_RMWW = 7'h08,
      S_PUSHPC = 7'h10,
      S_PUSHCCR = 7'h20,
      S_RSTX = 7'h40
   } cia_state_e;

   function automatic cia_rgn_e rgn_of(input logic [15:0] a);
      if (a <= VEC_HI) rgn_of = RG_VEC; // RULE9
      else if (a <= ROM_HI) rgn_of = RG_ROM;
      else if (a >= IO1_LO && a <= IO1_HI) rgn_of = RG_IO; // RULE10
      else if (a >= RAM_LO && a <= RAM_HI) rgn_of = RG_RAM;
      else if (a >= IO2_LO) rgn_of = RG_IO; // RULE11
      else rgn_of = RG_EMPTY; // RULE3
   endfunction

   function automatic logic [1:0] states_of(input logic [15:0] a);
      if ((a >= IO1_LO && a <= IO1_HI) || (a >= SCI_LO && a <= SCI_HI) || (a >= TMV_LO && a <= TMV_HI))
         states_of = ST_SLOW; // RULE12
      else
         states_of = ST_FAST; // RULE19
   endfunction

   function automatic logic [7:0] modify(input logic [7:0] d, input cia_bop_e op, input logic [2:0] n,
                                         input logic c);
      logic [7:0] r;
      r = d;
      case (op)
         BOP_SET: r[n] = 1'b1;
         BOP_CLR: r[n] = 1'b0;
         BOP_INV: r[n] = ~d[n];
         BOP_STO: r[n] = c;
         BOP_ISTO: r[n] = ~c;
         default: r = d;
      endcase
      modify = r; // RULE22
   endfunction

   cia_state_e state;
   cia_state_e next_state;
   cia_acc_s cur;
   cia_acc_s next_cur;
   logic launch;
   logic [1:0] cnt;
   logic complete;
   cia_bop_e rmw_op;
   logic [2:0] rmw_bit;
   logic rmw_c;
   logic [15:0] ccr_sp;
   logic [15:0] ram [RAM_WORDS];
   logic [RAM_AW-1:0] ram_idx;
   logic [15:0] ram_off;
   cia_rgn_e rgn;
   logic [7:0] pin_s1;
   logic [7:0] pin_s2;
   logic [7:0] port_latch;
   logic [7:0] port_dir;
   logic [7:0] rld_cnt;
   logic [7:0] rld_load;
   logic [7:0] io_byte;
   logic [15:0] rd_word;
   logic [7:0] rd_byte;
   logic [7:0] wr_byte;
   logic io_ext;

   assign rgn = rgn_of(cur.addr);
   assign ram_off = cur.addr - RAM_LO;
   assign ram_idx = ram_off[RAM_AW:1];
   assign complete = (state != S_IDLE) && (state != S_RSTX) && (cnt == 2'd1); // RULE18
   // Word I/O writes carry their byte in the upper lane
   assign wr_byte = cur.word ? cur.wdata[15:8] : cur.wdata[7:0]; // RULE7
   assign io_ext = (cur.addr != RLD_ADDR) && (cur.addr != PDATA_ADDR) && (cur.addr != PDIR_ADDR);

   // Pins are asynchronous to the core
   always_ff @(posedge core_clk)
   begin
      pin_s1 <= port_pin;
      pin_s2 <= pin_s1;
   end

   always_comb
   begin
      if (cur.addr == RLD_ADDR) io_byte = rld_cnt; // RULE14
      else if (cur.addr == PDATA_ADDR) io_byte = (port_dir & port_latch) | (~port_dir & pin_s2); // RULE16
      else if (cur.addr == PDIR_ADDR) io_byte = WO_READ; // RULE20
      else io_byte = per_rdata; // RULE6
   end

   always_comb
   begin
      case (rgn)
         RG_VEC, RG_ROM: rd_word = rom_rdata;
         RG_RAM: rd_word = ram[ram_idx];
         RG_IO: rd_word = {io_byte, 8'h00}; // RULE8
         default: rd_word = 16'h0000; // RULE5
      endcase
      if (rgn == RG_IO) rd_byte = io_byte;
      else rd_byte = cur.addr[0] ? rd_word[7:0] : rd_word[15:8];
   end

   always_comb
   begin
      next_state = state;
      next_cur = cur;
      launch = 1'b0;
      case (state)
         S_IDLE:
         begin
            if (exc_req.valid && exc_req.irq)
            begin
               launch = 1'b1;
               next_cur = '{we: 1'b1, word: 1'b1, addr: exc_req.sp - STACK_STEP, wdata: exc_req.pc}; // RULE2
               next_state = S_PUSHPC; // RULE1
            end
            else if (exc_req.valid)
               next_state = S_RSTX; // RULE1
            else if (cpu_req.valid)
            begin
               launch = 1'b1;
               next_cur.we = cpu_req.we && (cpu_req.op == BOP_NONE);
               next_cur.word = cpu_req.word && (cpu_req.op == BOP_NONE);
               next_cur.addr = cpu_req.addr;
               next_cur.wdata = cpu_req.wdata;
               next_state = (cpu_req.op == BOP_NONE) ? S_CPU : S_RMWR; // RULE13
            end
         end
         S_RMWR:
            if (complete)
            begin
               // Back to back, same address, so no other access can slip in
               launch = 1'b1;
               next_cur.we = 1'b1; // RULE21
               next_cur.word = 1'b0;
               next_cur.wdata = {8'h00, modify(rd_byte, rmw_op, rmw_bit, rmw_c)}; // RULE13
               next_state = S_RMWW;
            end
         S_PUSHPC:
            if (complete)
            begin
               launch = 1'b1;
               next_cur = '{we: 1'b1, word: 1'b1, addr: ccr_sp, wdata: {exc_req.condition_code_reg, exc_req.condition_code_reg}}; // RULE2
               next_state = S_PUSHCCR;
            end
         S_CPU, S_RMWW, S_PUSHCCR:
            if (complete) next_state = S_IDLE;
         S_RSTX: next_state = S_IDLE;
         default: next_state = S_IDLE;
      endcase
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         state <= S_IDLE;
         cur <= '0;
         cnt <= 2'd0;
      end
      else
      begin
         state <= next_state;
         if (launch)
         begin
            cur <= next_cur;
            // A fresh request already spent one state waiting; a chained phase gets them all
            cnt <= (state == S_IDLE) ? states_of(next_cur.addr) - 2'd1 : states_of(next_cur.addr); // RULE18
         end
         else if (cnt != 2'd0)
            cnt <= cnt - 2'd1;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         rmw_op <= BOP_NONE;
         rmw_bit <= 3'd0;
         rmw_c <= 1'b0;
         ccr_sp <= 16'h0000;
      end
      else if (state == S_IDLE)
      begin
         rmw_op <= cpu_req.op;
         rmw_bit <= cpu_req.bitn;
         rmw_c <= cpu_req.carry;
         ccr_sp <= exc_req.sp - STACK_STEP - STACK_STEP;
      end
   end

   // RAM holds no reset; ROM and empty space never take writes
   always_ff @(posedge core_clk)
   begin
      if (complete && cur.we && rgn == RG_RAM) // RULE4
      begin
         if (cur.word) ram[ram_idx] <= cur.wdata; // RULE19
         else if (cur.addr[0]) ram[ram_idx][7:0] <= cur.wdata[7:0];
         else ram[ram_idx][15:8] <= cur.wdata[7:0];
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         port_latch <= PDATA_RST;
         port_dir <= PDIR_RST;
      end
      else if (complete && cur.we && rgn == RG_IO)
      begin
         if (cur.addr == PDATA_ADDR) port_latch <= wr_byte;
         if (cur.addr == PDIR_ADDR) port_dir <= wr_byte;
      end
   end

   // The counter free-runs, so RMW through the shared address copies a moving count
   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         rld_cnt <= RLD_RST;
         rld_load <= RLD_RST;
      end
      else
      begin
         rld_cnt <= (rld_cnt == RLD_TOP) ? rld_load : rld_cnt + 8'd1;
         if (complete && cur.we && cur.addr == RLD_ADDR) rld_load <= wr_byte; // RULE15
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         per_bus <= '0;
         rom_addr <= 16'h0000;
      end
      else if (launch)
      begin
         per_bus.stb <= (rgn_of(next_cur.addr) == RG_IO) && (next_cur.addr != RLD_ADDR)
                        && (next_cur.addr != PDATA_ADDR) && (next_cur.addr != PDIR_ADDR);
         per_bus.we <= next_cur.we;
         per_bus.addr <= next_cur.addr;
         per_bus.wdata <= next_cur.word ? next_cur.wdata[15:8] : next_cur.wdata[7:0]; // RULE6
         rom_addr <= next_cur.addr;
      end
      else if (complete)
         per_bus.stb <= 1'b0;
   end

   always_ff @(posedge core_clk)
   begin
      if (!nrst)
      begin
         cpu_busy <= 1'b0;
         cpu_ack <= 1'b0;
         cpu_rdata <= 16'h0000;
         exc_busy <= 1'b0;
         exc_done <= 1'b0;
         exc_sp <= 16'h0000;
         port_out <= PDATA_RST;
         port_oe <= PDIR_RST;
      end
      else
      begin
         cpu_busy <= next_state != S_IDLE;
         cpu_ack <= complete && (state == S_CPU || state == S_RMWW);
         if (complete && state == S_CPU && !cur.we)
            cpu_rdata <= cur.word ? rd_word : {8'h00, rd_byte};
         exc_busy <= next_state == S_PUSHPC || next_state == S_PUSHCCR || next_state == S_RSTX; // RULE1
         exc_done <= (complete && state == S_PUSHCCR) || state == S_RSTX;
         if (state == S_IDLE && exc_req.valid && exc_req.irq)
            exc_sp <= exc_req.sp - STACK_STEP - STACK_STEP;
         port_out <= (complete && cur.we && cur.addr == PDATA_ADDR) ? wr_byte : port_latch;
         port_oe <= (complete && cur.we && cur.addr == PDIR_ADDR) ? wr_byte : port_dir;
      end
   end

   default clocking dc @(posedge core_clk); endclocking
   default disable iff (!nrst);

   logic take_plain;
   assign take_plain = state == S_IDLE && !exc_req.valid && cpu_req.valid && cpu_req.op == BOP_NONE;
   sequence seq_ack2;
      !cpu_ack ##1 cpu_ack;
   endsequence
   sequence seq_ack3;
      !cpu_ack [*2] ##1 cpu_ack;
   endsequence

   a_exc_entry_busy: assert property ((state == S_IDLE && exc_req.valid) |=> exc_busy) // RULE1
      else $error("exception state not entered");
   a_push_pc_addr: assert property ((state == S_IDLE && exc_req.valid && exc_req.irq) |=> // RULE2
      (cur.addr == 16'($past(exc_req.sp) - 16'h0002) && cur.wdata == $past(exc_req.pc)))
      else $error("PC push at wrong place");
   a_slow_io_states: assert property ((take_plain && states_of(cpu_req.addr) == ST_SLOW) |=> seq_ack3) // RULE12
      else $error("slow window not three states");
   a_fast_mem_states: assert property ((take_plain && rgn_of(cpu_req.addr) == RG_RAM) |=> seq_ack2) // RULE19
      else $error("memory access not two states");
   a_io_word_read: assert property ((complete && state == S_CPU && !cur.we && cur.word && rgn == RG_IO) // RULE8
      |=> cpu_rdata[7:0] == 8'h00)
      else $error("word I/O read low half wrong");
   a_rmw_same_addr: assert property ((state == S_RMWR && complete) |=> // RULE21
      (state == S_RMWW && cur.we && cur.addr == $past(cur.addr)))
      else $error("RMW write moved address");
   a_rmw_one_bit: assert property ((state == S_RMWR && complete) |=> // RULE22
      ($countones(cur.wdata[7:0] ^ $past(rd_byte)) <= 1))
      else $error("RMW changed more than one bit");
   a_shared_load: assert property ((complete && cur.we && cur.addr == RLD_ADDR) |=> // RULE15
      rld_load == $past(wr_byte))
      else $error("shared write missed load register");
   a_wo_reads_ones: assert property ((complete && state == S_CPU && !cur.we && !cur.word && cur.addr == PDIR_ADDR) // RULE20
      |=> cpu_rdata == 16'h00ff)
      else $error("write-only register not all ones");
endmodule

// ### verification/cia_per_model.sv
// Peripheral and ROM side model for the CPU internal access decoder
module cia_per_model
   import cia_pkg::*;
(
   input wire logic core_clk,
   input wire cia_pkg::cia_per_s per_bus,
   input wire logic [15:0] rom_addr,
   output logic [7:0] per_rdata,
   output logic [15:0] rom_rdata,
   output logic [15:0] wr_addr,
   output logic [7:0] wr_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] last = 8'h00;
   // Address-derived data, so every read is predictable without storage
   assign rom_rdata = rom_addr ^ 16'h5a5a;
   // Released bus shows the inverse of the last byte, never a stale copy
   assign per_rdata = (per_bus.stb && !per_bus.we) ? (per_bus.addr[7:0] ^ 8'hc3) : ~last;
   always @(posedge core_clk)
   begin
      if (per_bus.stb && !per_bus.we)
         last <= per_rdata;
      if (per_bus.stb && per_bus.we)
      begin
         wr_addr <= per_bus.addr;
         wr_data <= per_bus.wdata;
      end
   end
endmodule

// ### verification/test_cia_top.sv
// Self-checking testbench for the CPU internal access decoder
module test_cia_top
   import cia_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   cia_req_s cpu_req = '0;
   cia_exc_s exc_req = '0;
   logic [7:0] port_pin = 8'h40;
   logic [15:0] rom_rdata, rom_addr, cpu_rdata, exc_sp, wr_addr, rd;
   logic [7:0] per_rdata, port_out, port_oe, wr_data;
   cia_per_s per_bus;
   logic cpu_busy, cpu_ack, exc_busy, exc_done;
   int num_errors = 0;
   int n_compared = 0;
   int n;
   always #12.5 core_clk = ~core_clk;
   cia_top i_cia_top (.core_clk(core_clk), .nrst(nrst), .cpu_req(cpu_req), .exc_req(exc_req),
      .rom_rdata(rom_rdata), .per_rdata(per_rdata), .port_pin(port_pin), .per_bus(per_bus),
      .rom_addr(rom_addr), .cpu_busy(cpu_busy), .cpu_ack(cpu_ack), .cpu_rdata(cpu_rdata),
      .exc_busy(exc_busy), .exc_done(exc_done), .exc_sp(exc_sp), .port_out(port_out), .port_oe(port_oe));
   cia_per_model i_cia_per_model (.core_clk(core_clk), .per_bus(per_bus), .rom_addr(rom_addr),
      .per_rdata(per_rdata), .rom_rdata(rom_rdata), .wr_addr(wr_addr), .wr_data(wr_data));
   task automatic test_done;
      $display("Compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_compared++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // Request is dropped after its take edge: a held valid would be taken again
   task automatic acc(input logic we, input logic word, input logic [15:0] a, input logic [15:0] d,
      input cia_bop_e op, input logic [2:0] b, input logic c, output logic [15:0] q, output int k);
      @(posedge core_clk);
      cpu_req <= '{valid: 1'b1, we: we, word: word, addr: a, wdata: d, op: op, bitn: b, carry: c};
      @(posedge core_clk);
      cpu_req.valid <= 1'b0;
      // The request cycle counts as the first state
      k = 1;
      do
      begin
         @(posedge core_clk);
         #1;
         k++;
      end
      while (k < 20 && cpu_ack !== 1'b1);
      if (cpu_ack !== 1'b1)
      begin
         chk(1'b0, 1'b1, "access timeout");
         test_done();
      end
      q = cpu_rdata;
   endtask
   task automatic exc(input cia_exc_s e, output int k);
      @(posedge core_clk);
      exc_req <= e;
      @(posedge core_clk);
      exc_req.valid <= 1'b0;
      k = 1;
      do
      begin
         @(posedge core_clk);
         #1;
         k++;
      end
      while (k < 20 && exc_done !== 1'b1);
      if (exc_done !== 1'b1)
      begin
         chk(1'b0, 1'b1, "exception timeout");
         test_done();
      end
   endtask
   function automatic logic [7:0] bop(input cia_bop_e op, input logic [7:0] v, input logic [2:0] b, input logic c);
      case (op)
         BOP_SET: v[b] = 1'b1;
         BOP_CLR: v[b] = 1'b0;
         BOP_INV: v[b] = ~v[b];
         BOP_STO: v[b] = c;
         BOP_ISTO: v[b] = ~c;
         default: ;
      endcase
      return v;
   endfunction
   task automatic t_mem;
      acc(1, 0, 16'hfb80, 16'h00a5, BOP_NONE, 0, 0, rd, n);
      chk(n, 2, "RAM write states");
      acc(1, 1, 16'hfc00, 16'h1234, BOP_NONE, 0, 0, rd, n);
      acc(0, 1, 16'hfc00, 0, BOP_NONE, 0, 0, rd, n);
      chk(rd, 16'h1234, "RAM word");
      acc(0, 1, 16'h0100, 0, BOP_NONE, 0, 0, rd, n);
      chk(rd, 16'h0100 ^ 16'h5a5a, "ROM word");
      chk(n, 2, "ROM states");
      acc(0, 1, 16'h0010, 0, BOP_NONE, 0, 0, rd, n);
      chk(rd, 16'h0010 ^ 16'h5a5a, "vector word");
   endtask
   // Empty write at an address whose low bits alias the first RAM byte
   task automatic t_empty;
      acc(1, 0, 16'h8000, 16'h005a, BOP_NONE, 0, 0, rd, n);
      acc(1, 0, 16'hff80, 16'h005a, BOP_NONE, 0, 0, rd, n);
      acc(0, 0, 16'hfb80, 0, BOP_NONE, 0, 0, rd, n);
      chk(rd, 16'h00a5, "RAM after empty write");
      acc(0, 0, 16'h8000, 0, BOP_NONE, 0, 0, rd, n);
      chk(rd, 16'h0000, "empty read");
   endtask
   task automatic t_io;
      logic [15:0] ad [11] = '{16'hf770, 16'hf776, 16'hf77f, 16'hffa0, 16'hffa7, 16'hffa8, 16'hffad,
         16'hffae, 16'hffb8, 16'hffbd, 16'hffbe};
      int st [11] = '{3, 3, 3, 2, 2, 3, 3, 2, 3, 3, 2};
      for (int i = 0; i < 11; i++)
      begin
         acc(0, 0, ad[i], 0, BOP_NONE, 0, 0, rd, n);
         chk(rd, {8'h00, ad[i][7:0] ^ 8'hc3}, "I/O byte");
         chk(n, st[i], "I/O states");
      end
      acc(1, 1, 16'hffa2, 16'hc33c, BOP_NONE, 0, 0, rd, n);
      chk(wr_data, 8'hc3, "word write byte");
      chk(wr_addr, 16'hffa2, "word write address");
      acc(0, 1, 16'hffa2, 0, BOP_NONE, 0, 0, rd, n);
      chk(rd, 16'h6100, "word read");
   endtask
   // Pins 7 and 6 inputs, latch 80, pins 40: a bit set reads 40 back
   task automatic t_port;
      acc(1, 0, 16'hffe6, 16'h003f, BOP_NONE, 0, 0, rd, n);
      chk(port_oe, 8'h3f, "direction");
      acc(0, 0, 16'hffe6, 0, BOP_NONE, 0, 0, rd, n);
      chk(rd, 16'h00ff, "write-only read");
      acc(1, 0, 16'hffd6, 16'h0080, BOP_NONE, 0, 0, rd, n);
      repeat (4) @(posedge core_clk);
      acc(0, 0, 16'hffd6, 0, BOP_NONE, 0, 0, rd, n);
      chk(rd, 16'h0040, "port read");
      acc(0, 0, 16'hffd6, 0, BOP_SET, 0, 0, rd, n);
      chk(port_out, 8'h41, "port bit set");
      acc(0, 0, 16'hffe6, 0, BOP_CLR, 0, 0, rd, n);
      chk(port_oe, 8'hfe, "direction bit clear");
      acc(1, 0, 16'hffe6, 16'h003e, BOP_NONE, 0, 0, rd, n);
      chk(port_oe, 8'h3e, "shadow write");
   endtask
   task automatic t_rmw;
      logic [7:0] v;
      cia_bop_e ops [5] = '{BOP_SET, BOP_CLR, BOP_INV, BOP_STO, BOP_ISTO};
      logic [2:0] bs [5] = '{3'd7, 3'd1, 3'd0, 3'd7, 3'd2};
      v = 8'h5a;
      acc(1, 0, 16'hfb90, {8'h00, v}, BOP_NONE, 0, 0, rd, n);
      for (int i = 0; i < 5; i++)
      begin
         acc(0, 0, 16'hfb90, 0, ops[i], bs[i], i[0], rd, n);
         chk(n, 4, "RMW states");
         v = bop(ops[i], v, bs[i], i[0]);
         acc(0, 0, 16'hfb90, 0, BOP_NONE, 0, 0, rd, n);
         chk(rd, {8'h00, v}, "RMW result");
      end
      acc(0, 0, 16'hffa4, 0, BOP_INV, 2, 0, rd, n);
      chk(n, 4, "I/O RMW states");
      chk(wr_addr, 16'hffa4, "RMW write address");
      chk(wr_data, 8'h63, "RMW write byte");
   endtask
   // Load FC makes the free-running count cycle FC..FF; the two reads sit three cycles apart
   task automatic t_rld;
      logic [7:0] cnt_a;
      acc(1, 0, RLD_ADDR, 16'h00fc, BOP_NONE, 0, 0, rd, n);
      repeat (260) @(posedge core_clk);
      acc(0, 0, RLD_ADDR, 0, BOP_NONE, 0, 0, rd, n);
      cnt_a = rd[7:0];
      acc(0, 0, RLD_ADDR, 0, BOP_NONE, 0, 0, rd, n);
      chk({8'h00, cnt_a & 8'hfc}, 16'h00fc, "count after reload");
      chk(rd, {8'h00, 8'hfc | ((cnt_a + 8'd3) & 8'h03)}, "count read");
   endtask
   task automatic t_exc;
      exc('{valid: 1'b1, irq: 1'b1, pc: 16'h1234, condition_code_reg: 8'ha5, sp: 16'hff00}, n);
      chk(n, 4, "interrupt push time");
      chk(exc_sp, 16'hfefc, "stack after push");
      acc(0, 1, 16'hfefe, 0, BOP_NONE, 0, 0, rd, n);
      chk(rd, 16'h1234, "pushed PC");
      acc(0, 1, 16'hfefc, 0, BOP_NONE, 0, 0, rd, n);
      chk(rd, 16'ha5a5, "pushed condition codes");
      exc('{valid: 1'b1, irq: 1'b0, pc: 16'h0000, condition_code_reg: 8'h00, sp: 16'hff00}, n);
      chk(n, 2, "reset cause time");
   endtask
   initial
   begin
      repeat (16) @(posedge core_clk);
      nrst <= 1'b1;
      #1;
      chk({cpu_ack, cpu_busy, exc_busy, exc_done, port_oe}, 0, "reset outputs");
      t_mem();
      t_empty();
      t_io();
      t_port();
      t_rmw();
      t_rld();
      t_exc();
      test_done();
   end
endmodule
